// File: regbank_defines.svh
// register bank constants: offsets, widths, reset values
`ifndef REGBANK_DEFINES_SVH
`define REGBANK_DEFINES_SVH
`define RB_DATA_W        32
`define RB_ADDR_W        4
`define RB_OFF_RWREG     4'h0
`define RB_OFF_ROREG     4'h1
`define RB_OFF_WOREG     4'h2
`define RB_OFF_DBGREG    4'h3
`define RB_OFF_SETREG    4'h4
`define RB_OFF_CLRREG    4'h5
`define RB_RW_MASK       32'h00ff_ffff
`define RB_RW_RESET      32'h0000_0000
`define RB_WO_RESET      32'h0000_0000
`define RB_DBG_MASK      32'h0000_00ff
`define RB_DBG_RESET     32'h0000_0000
`define RB_SC_MASK       32'h0000_ffff
`define RB_SC_RESET      32'h0000_0000
`endif

// File: regbank_pkg.sv
// register bank types
package regbank_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;
    typedef enum logic [1:0] {
        RESET_NONE,
        RESET_SOFT,
        RESET_POWER
    } reset_kind_t;
endpackage

// File: set_clear_pair.sv
// set and clear alias pair over one shared value
`timescale 1ns/10ps
`include "regbank_defines.svh"
module set_clear_pair #(
    parameter int          WIDTH = 32,
    parameter logic [31:0] MASK  = `RB_SC_MASK,
    parameter logic [31:0] RSTV  = `RB_SC_RESET
) (
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             soft_rst_in,
    input  wire logic             set_we_in,
    input  wire logic             clr_we_in,
    input  wire logic [WIDTH-1:0] set_data_in,
    input  wire logic [WIDTH-1:0] clr_data_in,
    output logic      [WIDTH-1:0] value_out
);
    logic [WIDTH-1:0] value_r;
    logic [WIDTH-1:0] value_nxt;
    logic [WIDTH-1:0] set_bits;
    logic [WIDTH-1:0] clr_bits;

    // ones set, ones clear, zeros keep; clear applied last so it wins
    always_comb begin
        set_bits  = set_we_in ? set_data_in : '0; // [RQ8] [RQ11]
        clr_bits  = clr_we_in ? clr_data_in : '0; // [RQ7] [RQ11]
        value_nxt = ((value_r | set_bits) & ~clr_bits) // [RQ10]
                    & MASK[WIDTH-1:0];
    end

    // shared storage, reset by power or soft reset
    always_ff @(posedge clk_in) begin
        if (!resetn_in || soft_rst_in) begin
            value_r <= RSTV[WIDTH-1:0]; // [RQ6]
        end else begin
            value_r <= value_nxt;
        end
    end

    assign value_out = value_r;

    // a bit written one through both aliases at once ends cleared
    clear_wins_a: assert property (@(posedge clk_in) // [RQ10]
        disable iff (!resetn_in)
        (set_we_in && clr_we_in && !soft_rst_in) |=>
        ((value_r & $past(set_data_in & clr_data_in)) == '0))
        else $error("clear did not win over set");

    // set ones inside the mask that no clear contests end set
    set_takes_a: assert property (@(posedge clk_in) // [RQ8]
        disable iff (!resetn_in)
        (set_we_in && !soft_rst_in) |=>
        ((value_r & $past(set_data_in & ~clr_bits) & MASK[WIDTH-1:0])
         == ($past(set_data_in & ~clr_bits) & MASK[WIDTH-1:0])))
        else $error("set alias did not set bits");

    // bits written zero through both aliases keep their value
    zero_keeps_a: assert property (@(posedge clk_in) // [RQ11]
        disable iff (!resetn_in)
        ((set_we_in || clr_we_in) && !soft_rst_in) |=>
        (((value_r ^ $past(value_r)) & ~$past(set_bits | clr_bits)) == '0))
        else $error("zero bits changed shared value");
    cover_both_c: cover property (@(posedge clk_in) set_we_in && clr_we_in);
endmodule

// File: register_access_conventions.sv
// register bank showing each access class of the peripheral registers
// How it works
// (RQ1) read-write bits store writes, read back
// (RQ2) read-only bits ignore writes, read status
// (RQ3) write-only bits accept writes, read undefined
// (RQ4) reserved bit positions always read zero
// (RQ5) software writes zero into reserved bits
// (RQ6) resets restore values; soft spares debug
// (RQ7) clear alias ones clear shared bits
// (RQ8) set alias ones set shared bits
// (RQ9) both aliases read the same value
// (RQ10) simultaneous set and clear: clear wins
// (RQ11) zero bits leave shared bits unchanged
`timescale 1ns/10ps
`include "regbank_defines.svh"
module register_access_conventions #(
    parameter int DW = `RB_DATA_W
) (
    input  wire logic                    clk_in,
    input  wire logic                    resetn_in,
    input  wire logic                    soft_rst_in,
    input  wire regbank_pkg::reg_req_t   req_in,
    input  wire regbank_pkg::reg_req_t   req2_in,
    input  wire logic [DW-1:0]           status_in,
    output logic      [DW-1:0]           rdata_out,
    output logic                         rvalid_out,
    output logic      [DW-1:0]           control_out,
    output logic      [DW-1:0]           command_out,
    output logic      [DW-1:0]           debug_out,
    output logic      [DW-1:0]           flags_out
);
    logic [DW-1:0] rw_r;
    logic [DW-1:0] wo_r;
    logic [DW-1:0] dbg_r;
    logic [DW-1:0] sc_val;
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;
    logic          rvalid_r;
    logic          set_we;
    logic          clr_we;
    logic [DW-1:0] set_data;
    logic [DW-1:0] clr_data;

    // write strobe for one offset on one request port
    function automatic logic wr_hit(input regbank_pkg::reg_req_t r,
                                    input logic [3:0] off);
        wr_hit = r.valid && r.write && (r.addr == off);
    endfunction

    // what the two ports write to one alias; a port that misses adds zeros
    // so that the data of one alias never leaks into the other
    function automatic logic [31:0] alias_data(
        input regbank_pkg::reg_req_t a,
        input regbank_pkg::reg_req_t b,
        input logic [3:0]            off);
        alias_data = (wr_hit(a, off) ? a.wdata : 32'h0000_0000)
                     | (wr_hit(b, off) ? b.wdata : 32'h0000_0000);
    endfunction

    // read-write register, reserved bits never stored
    always_ff @(posedge clk_in) begin
        if (!resetn_in || soft_rst_in) begin
            rw_r <= `RB_RW_RESET; // [RQ6]
        end else if (wr_hit(req_in, `RB_OFF_RWREG)) begin
            rw_r <= req_in.wdata & `RB_RW_MASK; // [RQ1] [RQ4]
        end
    end

    // write-only command register
    always_ff @(posedge clk_in) begin
        if (!resetn_in || soft_rst_in) begin
            wo_r <= `RB_WO_RESET; // [RQ6]
        end else if (wr_hit(req_in, `RB_OFF_WOREG)) begin
            wo_r <= req_in.wdata; // [RQ3]
        end
    end

    // debug control, untouched by soft reset
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            dbg_r <= `RB_DBG_RESET; // [RQ6]
        end else if (wr_hit(req_in, `RB_OFF_DBGREG)) begin
            dbg_r <= req_in.wdata & `RB_DBG_MASK; // [RQ4]
        end
    end

    // set and clear aliases; second port lets both land in one cycle
    always_comb begin
        set_we   = wr_hit(req_in, `RB_OFF_SETREG)
                   || wr_hit(req2_in, `RB_OFF_SETREG);
        clr_we   = wr_hit(req_in, `RB_OFF_CLRREG)
                   || wr_hit(req2_in, `RB_OFF_CLRREG);
        set_data = alias_data(req_in, req2_in, `RB_OFF_SETREG); // [RQ8]
        clr_data = alias_data(req_in, req2_in, `RB_OFF_CLRREG); // [RQ7]
    end

    set_clear_pair #(
        .WIDTH (DW),
        .MASK  (`RB_SC_MASK),
        .RSTV  (`RB_SC_RESET)
    ) u_pair (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .soft_rst_in  (soft_rst_in),
        .set_we_in    (set_we),
        .clr_we_in    (clr_we),
        .set_data_in  (set_data),
        .clr_data_in  (clr_data),
        .value_out    (sc_val)
    );

    // read mux; write-only returns zero, unmapped returns zero
    always_comb begin
        case (req_in.addr)
            `RB_OFF_RWREG:  rdata_nxt = rw_r; // [RQ1]
            `RB_OFF_ROREG:  rdata_nxt = status_in; // [RQ2]
            `RB_OFF_WOREG:  rdata_nxt = '0; // [RQ3]
            `RB_OFF_DBGREG: rdata_nxt = dbg_r;
            `RB_OFF_SETREG: rdata_nxt = sc_val; // [RQ9]
            `RB_OFF_CLRREG: rdata_nxt = sc_val; // [RQ9]
            default:        rdata_nxt = '0; // [RQ4]
        endcase
    end

    // registered read data, one cycle after request
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= req_in.valid && !req_in.write;
            if (req_in.valid && !req_in.write) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign rdata_out   = rdata_r;
    assign rvalid_out  = rvalid_r;
    assign control_out = rw_r;
    assign command_out = wo_r;
    assign debug_out   = dbg_r;
    assign flags_out   = sc_val;

    // software is expected to keep reserved bits zero when it writes;
    // the masks above drop them, except in the write-only register, which stores the whole word

    // a write to the read-write register reads back through its mask
    rw_readback_a: assert property (@(posedge clk_in) // [RQ1]
        disable iff (!resetn_in)
        (wr_hit(req_in, `RB_OFF_RWREG) && !soft_rst_in) |=>
        (rw_r == ($past(req_in.wdata) & `RB_RW_MASK)))
        else $error("read-write bit did not store write");

    // read valid comes only in the cycle after a read request
    rvalid_pulse_a: assert property (@(posedge clk_in) // [RQ1]
        disable iff (!resetn_in)
        rvalid_out |-> $past(req_in.valid && !req_in.write))
        else $error("read valid without a read request");

    // a write aimed at the read-only offset leaves the read-write, write-only and debug stores alone
    ro_ignores_a: assert property (@(posedge clk_in) // [RQ2]
        disable iff (!resetn_in)
        (wr_hit(req_in, `RB_OFF_ROREG) && !soft_rst_in) |=>
        (rw_r == $past(rw_r)) && (wo_r == $past(wo_r))
        && (dbg_r == $past(dbg_r)))
        else $error("write to read-only offset changed a register");

    // the read-only offset returns the live status word
    ro_read_a: assert property (@(posedge clk_in) // [RQ2]
        disable iff (!resetn_in)
        (req_in.valid && !req_in.write && req_in.addr == `RB_OFF_ROREG)
        |=> rvalid_out && (rdata_out == $past(status_in)))
        else $error("read-only read value wrong");

    // the write-only register keeps the whole written word
    wo_store_a: assert property (@(posedge clk_in) // [RQ3]
        disable iff (!resetn_in)
        (wr_hit(req_in, `RB_OFF_WOREG) && !soft_rst_in) |=>
        (wo_r == $past(req_in.wdata)))
        else $error("write-only register did not take write");

    // reserved positions of the read-write, set/clear and debug stores stay zero
    reserved_zero_a: assert property (@(posedge clk_in) // [RQ4]
        disable iff (!resetn_in)
        ((rw_r & ~`RB_RW_MASK) == '0) && ((sc_val & ~`RB_SC_MASK) == '0)
        && ((dbg_r & ~`RB_DBG_MASK) == '0))
        else $error("reserved bit read nonzero");

    // offsets past the last register read back as zero
    unmapped_zero_a: assert property (@(posedge clk_in) // [RQ4]
        disable iff (!resetn_in)
        (req_in.valid && !req_in.write && (req_in.addr > `RB_OFF_CLRREG))
        |=> (rdata_out == '0))
        else $error("unmapped offset read nonzero");

    // soft reset spares the debug register
    soft_keeps_dbg_a: assert property (@(posedge clk_in) // [RQ6]
        disable iff (!resetn_in)
        (soft_rst_in && !wr_hit(req_in, `RB_OFF_DBGREG)) |=>
        (dbg_r == $past(dbg_r)) && (rw_r == `RB_RW_RESET))
        else $error("soft reset handling wrong");

    // soft reset returns the other stores to their reset values
    soft_clears_a: assert property (@(posedge clk_in) // [RQ6]
        disable iff (!resetn_in)
        soft_rst_in |=> (rw_r == `RB_RW_RESET) && (wo_r == `RB_WO_RESET)
        && (sc_val == `RB_SC_RESET))
        else $error("soft reset left a register set");

    // power reset returns every store, debug included, to reset values
    power_reset_a: assert property (@(posedge clk_in) // [RQ6]
        !resetn_in |=> (dbg_r == `RB_DBG_RESET) && (rw_r == `RB_RW_RESET)
        && (wo_r == `RB_WO_RESET) && (sc_val == `RB_SC_RESET))
        else $error("power reset left a register set");

    // both aliases read back the one shared value
    alias_same_a: assert property (@(posedge clk_in) // [RQ9]
        disable iff (!resetn_in)
        (req_in.valid && !req_in.write && (req_in.addr == `RB_OFF_SETREG
         || req_in.addr == `RB_OFF_CLRREG)) |=>
        (rdata_out == $past(sc_val)))
        else $error("alias reads differ from shared value");

    // ones written to the clear alias end cleared
    clr_clears_a: assert property (@(posedge clk_in) // [RQ7]
        disable iff (!resetn_in)
        (clr_we && !soft_rst_in) |=> ((sc_val & $past(clr_data)) == '0))
        else $error("clear alias did not clear bits");

    // main scenarios: write then read, soft reset, set then clear
    cover_rw_c: cover property (@(posedge clk_in)
        wr_hit(req_in, `RB_OFF_RWREG) ##[1:2] req_in.valid && !req_in.write);
    cover_soft_c: cover property (@(posedge clk_in) soft_rst_in);
    cover_sc_c: cover property (@(posedge clk_in) set_we ##[1:2] clr_we);
endmodule

// File: testbench.sv
// self-checking bench for the register access class bank
`timescale 1ns/10ps
`include "regbank_defines.svh"
module testbench;
    logic                  clk_in;
    logic                  resetn_in;
    logic                  soft_rst_in;
    regbank_pkg::reg_req_t req_in;
    regbank_pkg::reg_req_t req2_in;
    logic [31:0]           status_in;
    logic [31:0]           rdata_out;
    logic                  rvalid_out;
    logic [31:0]           control_out;
    logic [31:0]           command_out;
    logic [31:0]           debug_out;
    logic [31:0]           flags_out;
    int                    bad_count;
    int                    n_tests;
    int                    cycles = 0;

    // device under test
    register_access_conventions i_register_access_conventions (
        .clk_in(clk_in), .resetn_in(resetn_in), .soft_rst_in(soft_rst_in),
        .req_in(req_in), .req2_in(req2_in), .status_in(status_in),
        .rdata_out(rdata_out), .rvalid_out(rvalid_out),
        .control_out(control_out), .command_out(command_out),
        .debug_out(debug_out), .flags_out(flags_out));

    // 125 mhz clock
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // hang guard: whole run needs well under 200 cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // one write cycle on the primary port, optionally on the second port
    task automatic wr2(input logic [3:0] a, input logic [31:0] d,
                       input logic v2, input logic [3:0] a2,
                       input logic [31:0] d2);
        @(posedge clk_in);
        req_in <= {1'b1, 1'b1, a, d};
        req2_in <= {v2, 1'b1, a2, d2};
        @(posedge clk_in);
        req_in <= '0;
        req2_in <= '0;
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wr2(a, d, 1'b0, 4'h0, 32'h0);
    endtask

    // read request; valid stands for the one cycle after it is taken
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        req_in <= {1'b1, 1'b0, a, 32'h0};
        @(posedge clk_in);
        req_in <= '0;
        #1;
        cmp({31'h0, rvalid_out}, 32'h1);
        cmp(rdata_out, exp);
    endtask

    task automatic rw_class();
        wr(`RB_OFF_RWREG, 32'hffff_ffff);
        cmp(control_out, 32'h00ff_ffff);
        rd(`RB_OFF_RWREG, 32'h00ff_ffff);
        wr(`RB_OFF_RWREG, 32'h0012_3456);
        rd(`RB_OFF_RWREG, 32'h0012_3456);
        wr(4'hf, 32'hdead_beef);
        rd(4'hf, 32'h0000_0000);
    endtask

    task automatic ro_wo_class();
        wr(`RB_OFF_ROREG, 32'h0000_0000);
        rd(`RB_OFF_ROREG, 32'h1234_5678);
        wr(`RB_OFF_WOREG, 32'h0000_00a5);
        cmp(command_out, 32'h0000_00a5);
        cmp(control_out, 32'h0012_3456);
    endtask

    task automatic set_clear();
        wr(`RB_OFF_SETREG, 32'hffff_ffff);
        cmp(flags_out, 32'h0000_ffff);
        wr(`RB_OFF_CLRREG, 32'h0000_00f0);
        rd(`RB_OFF_SETREG, 32'h0000_ff0f);
        rd(`RB_OFF_CLRREG, 32'h0000_ff0f);
        wr2(`RB_OFF_SETREG, 32'h0000_0ff0,
            1'b1, `RB_OFF_CLRREG, 32'h0000_0f00);
        cmp(flags_out, 32'h0000_f0ff);
        wr2(`RB_OFF_CLRREG, 32'h0000_000f,
            1'b1, `RB_OFF_SETREG, 32'h0000_000f);
        cmp(flags_out, 32'h0000_f0f0);
    endtask

    task automatic resets();
        wr(`RB_OFF_DBGREG, 32'hffff_ffff);
        cmp(debug_out, 32'h0000_00ff);
        @(posedge clk_in);
        soft_rst_in <= 1'b1;
        @(posedge clk_in);
        soft_rst_in <= 1'b0;
        #1;
        cmp(control_out | command_out | flags_out, 32'h0);
        cmp(debug_out, 32'h0000_00ff);
        rd(`RB_OFF_DBGREG, 32'h0000_00ff);
        @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1;
        cmp(debug_out, 32'h0000_0000);
    endtask

    // main sequence
    initial begin
        resetn_in = 1'b0;
        soft_rst_in = 1'b0;
        req_in = '0;
        req2_in = '0;
        status_in = 32'h1234_5678;
        bad_count = 0;
        n_tests = 0;
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        rw_class();
        ro_wo_class();
        set_clear();
        resets();
        tally_and_finish();
    end
endmodule
